// ===== design/spr_pkg.sv
// package: register map, field positions, modes and timing for the sleep/power controller
package spr_pkg;
    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [11:0] ADDR_MCU_CONTROL = 12'h035;
    localparam logic [11:0] ADDR_POWER_REDUCTION = 12'h064;
    localparam logic [11:0] ADDR_SLEEP_MODE_CONTROL = 12'h054;
    localparam logic [11:0] ADDR_SLEEP_STATUS = 12'h058;
    // apb addresses: printed offsets are not all word aligned, so they are indices
    localparam logic [11:0] IDX_MCU_CONTROL = ADDR_MCU_CONTROL;
    localparam logic [11:0] IDX_POWER_REDUCTION = ADDR_POWER_REDUCTION;
    localparam logic [11:0] IDX_SLEEP_MODE_CONTROL = ADDR_SLEEP_MODE_CONTROL;
    localparam logic [11:0] IDX_SLEEP_STATUS = ADDR_SLEEP_STATUS;
    // ------------------------------------------------------------
    // field positions and masks
    // ------------------------------------------------------------
    localparam int SLEEP_GATE_BIT = 0;
    localparam int SLEEP_MODE_LSB = 1;
    localparam logic [7:0] SLEEP_MODE_CONTROL_MASK = 8'h0f;
    localparam int BROWNOUT_OFF_IN_SLEEP = 6;
    localparam int BROWNOUT_SLEEP_UNLOCK = 5;
    localparam int GLOBAL_PULLUP_DISABLE = 4;
    localparam int VECTOR_TABLE_SELECT = 1;
    localparam int VECTOR_CHANGE_UNLOCK = 0;
    localparam logic [7:0] MCU_CONTROL_MASK = 8'h33;
    localparam int GATE_TWO_WIRE_CLOCK = 7;
    localparam int GATE_TIMER2_CLOCK = 6;
    localparam int GATE_TIMER0_CLOCK = 5;
    localparam int GATE_TIMER1_CLOCK = 3;
    localparam int GATE_SERIAL_PERIPH_CLOCK = 2;
    localparam int GATE_UART_CLOCK = 1;
    localparam int GATE_CONVERTER_CLOCK = 0;
    localparam logic [7:0] POWER_REDUCTION_MASK = 8'hef;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    // ------------------------------------------------------------
    // timing in clock cycles
    // ------------------------------------------------------------
    localparam logic [2:0] UNLOCK_WINDOW_CYCLES = 3'd4;
    localparam logic [1:0] BROWNOUT_ACTIVE_DELAY = 2'd3;
    localparam logic [2:0] STANDBY_WAKE_CYCLES = 3'd6;
    // ------------------------------------------------------------
    // sleep modes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SPR_IDLE = 3'b000,
        SPR_ADC_NOISE = 3'b001,
        SPR_POWER_DOWN = 3'b010,
        SPR_POWER_SAVE = 3'b011,
        SPR_RSVD4 = 3'b100,
        SPR_RSVD5 = 3'b101,
        SPR_STANDBY = 3'b110,
        SPR_EXT_STANDBY = 3'b111
    } spr_mode_e;
    typedef enum logic [1:0] {
        SPR_ACTIVE = 2'b00,
        SPR_ASLEEP = 2'b01,
        SPR_WAKING = 2'b10
    } spr_state_e;
    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic two_wire;
        logic timer2;
        logic timer0;
        logic timer1;
        logic serial_periph;
        logic uart;
        logic converter;
    } spr_gate_s;
    typedef struct packed {
        spr_state_e state;
        spr_mode_e mode;
        logic [7:0] sleep_mode_control;
        logic [7:0] mcu_control;
        logic [7:0] power_reduction;
        logic [2:0] unlock_cnt;
        logic [1:0] arm_age;
        logic arm_active;
        logic detector_off;
        logic [2:0] wake_cnt;
        logic [31:0] prdata;
        logic adc_was_off;
        logic extended_conv;
    } spr_state_s;
endpackage

// ===== design/spr_sleep_ctrl.sv
// module: sleep mode, brown-out-in-sleep and peripheral clock gating controller
// ------------------------------------------------------------
// Overview of operation
// [RQ1] mode 110 with crystal: power-down but oscillator runs, resume in six cycles
// [RQ2] mode 111 with crystal: power-save but oscillator runs, wake in six cycles
// [RQ3] set power-reduction bit stops clock, freezes peripheral, blocks its register access
// [RQ4] clearing the bit restarts the clock, module resumes from held state
// [RQ5] per-module gating matters in active and idle only; deeper modes stop all (here noise mode keeps the adc clock; async timer 2 always runs)
// [RQ6] sleep mode control bits 7:4 read zero, writes ignored
// [RQ7] mode field bits 3:1: idle, noise, down, save, two reserved, standby, ext
// [RQ8] sleep instruction sleeps only while the sleep gate bit is one
// [RQ9] software first writes brown-out bit and unlock bit both one
// [RQ10] then bit one, unlock zero within four cycles sets it, else ignored
// [RQ11] brown-out bit active three cycles after set; sleep then turns detector off
// [RQ12] hardware clears brown-out bit three cycles after it was set
// [RQ13] bit 7 stops two-wire clock; software re-initialises it afterwards
// [RQ14] bit 6 stops timer 2 only when running synchronously
// [RQ15] bit 5 stops timer 0, bit 3 timer 1; both resume unchanged
// [RQ16] power-reduction bit 4 reads zero, writes ignored
// [RQ17] bit 2 stops spi clock; never set while one-wire debug in use
// [RQ18] bit 1 stops uart clock; software re-initialises it afterwards
// [RQ19] bit 0 stops adc; comparator loses adc mux while stopped (here comparator_enable is held off while bit 0 is set)
// [RQ20] input buffers off when io and adc clocks both stopped, except wake inputs
// [RQ21] enabled adc stays on in sleep; off-on cycle forces extended conversion
// [RQ22] comparator off in all modes but idle and noise; reference kept if used
// [RQ23] detector switched off for sleep is re-enabled on every wake-up
// [RQ24] reserved mode encodings leave the core running
// ------------------------------------------------------------
//
// Chosen here: register access over APB.
`timescale 1ns/10ps
module spr_sleep_ctrl #(
    parameter int WAKE_CYCLES = 6
) (
    // clock, reset, enable
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [13:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // core side
    input wire logic sleep_instr,
    input wire logic wake_event,
    input wire logic crystal_clock_sel,
    output logic core_halted,
    output logic core_resume,
    // peripheral side
    input wire logic timer2_async_select,
    input wire logic adc_enabled,
    input wire logic comparator_uses_ref,
    input wire logic periph_access,
    input wire logic [2:0] periph_sel,
    output logic periph_access_ok,
    output spr_pkg::spr_gate_s clock_run,
    output logic oscillator_run,
    output logic peripheral_io_clock_run,
    output logic converter_clock_run,
    output logic timer2_clock_run,
    output logic input_buffer_enable,
    output logic comparator_enable,
    output logic reference_keep,
    output logic adc_extended_conv,
    output logic brownout_detector_enable
);
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    if (WAKE_CYCLES < 1 || WAKE_CYCLES > 7) begin
        $error("WAKE_CYCLES must be 1 to 7");
    end

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function automatic logic deep_mode(input spr_pkg::spr_mode_e m);
        deep_mode = (m != spr_pkg::SPR_IDLE);
    endfunction

    function automatic logic io_stopped(input spr_pkg::spr_mode_e m);
        io_stopped = (m != spr_pkg::SPR_IDLE);
    endfunction

    function automatic logic adc_clk_stopped(input spr_pkg::spr_mode_e m);
        adc_clk_stopped = (m != spr_pkg::SPR_IDLE) && (m != spr_pkg::SPR_ADC_NOISE);
    endfunction

    function automatic logic [11:0] word_index(input logic [13:0] a);
        word_index = a[13:2];
    endfunction

    spr_pkg::spr_state_s cur;
    spr_pkg::spr_state_s nxt;
    logic asleep;
    logic wr_en;
    logic rd_en;
    logic [11:0] idx;
    spr_pkg::spr_mode_e sel_mode;
    logic [7:0] wb;

    assign asleep = (cur.state == spr_pkg::SPR_ASLEEP);
    assign idx = word_index(paddr);
    assign wr_en = psel && penable && pwrite;
    // read word loads in the setup cycle so it stands at the access edge
    assign rd_en = psel && !penable && !pwrite;
    assign sel_mode = spr_pkg::spr_mode_e'(cur.sleep_mode_control[3:1]); // RQ7
    assign wb = pwdata[7:0];

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        nxt = cur;
        // brown-out bit ages out after three cycles
        if (cur.mcu_control[spr_pkg::BROWNOUT_OFF_IN_SLEEP]) begin
            if (cur.arm_age == spr_pkg::BROWNOUT_ACTIVE_DELAY - 2'd1) begin
                nxt.mcu_control[spr_pkg::BROWNOUT_OFF_IN_SLEEP] = 1'b0; // RQ12
                nxt.arm_active = 1'b1; // RQ11
                nxt.arm_age = 2'd0;
            end else begin
                nxt.arm_age = cur.arm_age + 2'd1;
            end
        end else begin
            nxt.arm_active = 1'b0;
        end
        if (cur.arm_active) begin
            nxt.arm_active = 1'b0;
        end
        if (cur.unlock_cnt != 3'd0) begin
            nxt.unlock_cnt = cur.unlock_cnt - 3'd1;
        end
        // register writes
        if (wr_en) begin
            case (idx)
                spr_pkg::IDX_SLEEP_MODE_CONTROL: begin
                    nxt.sleep_mode_control = wb & spr_pkg::SLEEP_MODE_CONTROL_MASK; // RQ6
                end
                spr_pkg::IDX_POWER_REDUCTION: begin
                    nxt.power_reduction = wb & spr_pkg::POWER_REDUCTION_MASK; // RQ16
                end
                spr_pkg::IDX_MCU_CONTROL: begin
                    nxt.mcu_control[spr_pkg::GLOBAL_PULLUP_DISABLE] =
                        wb[spr_pkg::GLOBAL_PULLUP_DISABLE];
                    nxt.mcu_control[spr_pkg::VECTOR_TABLE_SELECT] =
                        wb[spr_pkg::VECTOR_TABLE_SELECT];
                    nxt.mcu_control[spr_pkg::VECTOR_CHANGE_UNLOCK] =
                        wb[spr_pkg::VECTOR_CHANGE_UNLOCK];
                    if (wb[spr_pkg::BROWNOUT_OFF_IN_SLEEP] && wb[spr_pkg::BROWNOUT_SLEEP_UNLOCK]) begin
                        nxt.unlock_cnt = spr_pkg::UNLOCK_WINDOW_CYCLES; // RQ9
                        nxt.mcu_control[spr_pkg::BROWNOUT_SLEEP_UNLOCK] = 1'b1;
                    end else if (wb[spr_pkg::BROWNOUT_OFF_IN_SLEEP] && cur.unlock_cnt != 3'd0) begin
                        nxt.mcu_control[spr_pkg::BROWNOUT_OFF_IN_SLEEP] = 1'b1; // RQ10
                        nxt.mcu_control[spr_pkg::BROWNOUT_SLEEP_UNLOCK] = 1'b0;
                        nxt.unlock_cnt = 3'd0;
                        nxt.arm_age = 2'd0;
                    end else begin
                        nxt.mcu_control[spr_pkg::BROWNOUT_SLEEP_UNLOCK] = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
        if (nxt.unlock_cnt == 3'd0) begin
            nxt.mcu_control[spr_pkg::BROWNOUT_SLEEP_UNLOCK] = 1'b0; // RQ10
        end
        // read data
        if (rd_en) begin
            case (idx)
                spr_pkg::IDX_SLEEP_MODE_CONTROL: nxt.prdata = {24'h0, cur.sleep_mode_control};
                spr_pkg::IDX_POWER_REDUCTION: nxt.prdata = {24'h0, cur.power_reduction};
                spr_pkg::IDX_MCU_CONTROL: nxt.prdata = {24'h0, cur.mcu_control};
                spr_pkg::IDX_SLEEP_STATUS: nxt.prdata =
                    {25'h0, cur.detector_off, cur.arm_active, cur.mode, cur.state};
                default: nxt.prdata = 32'h0;
            endcase
        end
        // adc off-on tracking
        if (!adc_enabled || cur.power_reduction[spr_pkg::GATE_CONVERTER_CLOCK]) begin
            nxt.adc_was_off = 1'b1;
        end else if (cur.adc_was_off) begin
            nxt.adc_was_off = 1'b0;
            nxt.extended_conv = 1'b1; // RQ21
        end else begin
            nxt.extended_conv = 1'b0;
        end
        // sleep sequencing
        case (cur.state)
            spr_pkg::SPR_ACTIVE: begin
                if (sleep_instr && cur.sleep_mode_control[spr_pkg::SLEEP_GATE_BIT] // RQ8
                        && sel_mode != spr_pkg::SPR_RSVD4
                        && sel_mode != spr_pkg::SPR_RSVD5) begin // RQ24
                    nxt.state = spr_pkg::SPR_ASLEEP;
                    nxt.mode = sel_mode;
                    nxt.detector_off = cur.arm_active && deep_mode(sel_mode); // RQ11
                end
            end
            spr_pkg::SPR_ASLEEP: begin
                if (wake_event) begin
                    nxt.state = spr_pkg::SPR_WAKING;
                    nxt.wake_cnt = 3'(WAKE_CYCLES - 1); // RQ1 RQ2
                    nxt.detector_off = 1'b0; // RQ23
                end
            end
            spr_pkg::SPR_WAKING: begin
                if (cur.wake_cnt == 3'd0) begin
                    nxt.state = spr_pkg::SPR_ACTIVE;
                    nxt.mode = spr_pkg::SPR_IDLE;
                end else begin
                    nxt.wake_cnt = cur.wake_cnt - 3'd1;
                end
            end
            default: begin
                nxt.state = spr_pkg::SPR_ACTIVE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // state register; clk_en freezes everything
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cur <= '0;
        end else if (clk_en) begin
            cur <= nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // zero-wait slave keeps the cpu write path simple
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign prdata = cur.prdata;
    assign core_halted = (cur.state != spr_pkg::SPR_ACTIVE);
    assign core_resume = (cur.state == spr_pkg::SPR_WAKING) && (cur.wake_cnt == 3'd0);

    logic io_run;
    logic adc_run;
    // crystal keeps running in idle, adc noise and standby modes only
    assign oscillator_run = !asleep || crystal_clock_sel &&
        (cur.mode == spr_pkg::SPR_STANDBY || cur.mode == spr_pkg::SPR_EXT_STANDBY) ||
        cur.mode == spr_pkg::SPR_IDLE || cur.mode == spr_pkg::SPR_ADC_NOISE; // RQ1 RQ2
    assign io_run = !(asleep && io_stopped(cur.mode)); // RQ5
    assign adc_run = !(asleep && adc_clk_stopped(cur.mode));
    assign peripheral_io_clock_run = io_run;
    assign converter_clock_run = adc_run;

    // gates hold the module clock low; its flops keep state until released
    assign clock_run.two_wire = io_run && !cur.power_reduction[spr_pkg::GATE_TWO_WIRE_CLOCK]; // RQ13 RQ3 RQ4
    assign clock_run.timer2 = timer2_async_select ||
        (io_run && !cur.power_reduction[spr_pkg::GATE_TIMER2_CLOCK]); // RQ14
    assign clock_run.timer0 = io_run && !cur.power_reduction[spr_pkg::GATE_TIMER0_CLOCK]; // RQ15
    assign clock_run.timer1 = io_run && !cur.power_reduction[spr_pkg::GATE_TIMER1_CLOCK]; // RQ15
    assign clock_run.serial_periph = io_run &&
        !cur.power_reduction[spr_pkg::GATE_SERIAL_PERIPH_CLOCK]; // RQ17
    assign clock_run.uart = io_run && !cur.power_reduction[spr_pkg::GATE_UART_CLOCK]; // RQ18
    assign clock_run.converter = adc_run &&
        !cur.power_reduction[spr_pkg::GATE_CONVERTER_CLOCK]; // RQ19
    assign timer2_clock_run = clock_run.timer2;

    // per-peripheral register access is blocked while its clock is stopped
    logic [6:0] run_vec;
    assign run_vec = clock_run;
    assign periph_access_ok = periph_access && periph_sel != 3'd7 && run_vec[periph_sel]; // RQ3

    assign input_buffer_enable = !(asleep && io_stopped(cur.mode) &&
        adc_clk_stopped(cur.mode)); // RQ20
    assign comparator_enable = !(asleep && adc_clk_stopped(cur.mode)) &&
        !cur.power_reduction[spr_pkg::GATE_CONVERTER_CLOCK]; // RQ22
    assign reference_keep = comparator_uses_ref || adc_enabled; // RQ22 RQ21
    assign adc_extended_conv = cur.extended_conv; // RQ21
    assign brownout_detector_enable = !(asleep && cur.detector_off); // RQ11 RQ23
endmodule

// ===== tb/spr_core_model.sv
// far-side model: core issuing sleep instructions plus a wake source
`timescale 1ns/10ps
module spr_core_model (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // bench commands
    input wire logic go_sleep,
    input wire logic go_wake,
    // controller side
    input wire logic core_resume,
    output logic sleep_instr,
    output logic wake_event
);
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sleep_instr <= 1'b0;
            wake_event <= 1'b0;
        end else begin
            sleep_instr <= go_sleep;
            // held like a pending interrupt, so a slow wake still sees it
            wake_event <= (wake_event || go_wake) && !core_resume;
        end
    end
endmodule

// ===== tb/spr_sleep_ctrl_monitor.sv
// checker: port-level assertions for the sleep and power controller
`timescale 1ns/10ps
module spr_sleep_ctrl_monitor #(
    parameter int WAKE_CYCLES = 6
) (
    // clock, reset, apb
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [13:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    // core side
    input wire logic sleep_instr,
    input wire logic wake_event,
    input wire logic crystal_clock_sel,
    input wire logic core_halted,
    input wire logic core_resume,
    // peripheral side
    input wire logic periph_access,
    input wire logic [2:0] periph_sel,
    input wire logic periph_access_ok,
    input wire spr_pkg::spr_gate_s clock_run,
    input wire logic oscillator_run,
    input wire logic comparator_enable,
    input wire logic brownout_detector_enable
);
    localparam logic [13:0] A_SMC = {spr_pkg::IDX_SLEEP_MODE_CONTROL, 2'b00};
    logic wr, rd, deep, waking;
    logic [6:0] run_v;
    logic [3:0] mode_shadow;
    assign wr = psel && penable && pwrite && clk_en;
    assign rd = psel && penable && !pwrite && clk_en;
    // modes 010 and up stop all module clocks but an async timer 2; shadow assumes no writes while halted
    assign deep = mode_shadow[3] || mode_shadow[2];
    assign run_v = clock_run;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            mode_shadow <= 4'h0;
        end else if (wr && paddr == A_SMC) begin
            mode_shadow <= pwdata[3:0];
        end
    end
    // clocks run again once a wake is taken, though the core stays halted
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            waking <= 1'b0;
        end else if (clk_en) begin
            waking <= core_halted && (waking || wake_event);
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    a_sleep_halts: assert property (sleep_instr && mode_shadow[0]
        && mode_shadow[3:2] != 2'b10 && !core_halted |=> core_halted)
        else $error("sleep did not halt the core");
    a_reserved_runs: assert property (sleep_instr && mode_shadow[3:2] == 2'b10
        && !core_halted |=> !core_halted) else $error("reserved mode halted the core");
    a_wake_bound: assert property ($rose(wake_event) && core_halted
        |-> ##[1:WAKE_CYCLES] core_resume) else $error("wake took too long");
    a_standby_osc: assert property (core_halted && crystal_clock_sel
        && mode_shadow[3:2] == 2'b11 |-> oscillator_run)
        else $error("oscillator off in standby");
    a_deep_gates: assert property (core_halted && !waking && deep
        |-> !run_v[1] && !run_v[6]) else $error("module clock running in deep sleep");
    a_access_blocked: assert property (periph_access && run_v[periph_sel] == 1'b0
        |-> !periph_access_ok) else $error("access allowed to a stopped module");
    a_comp_off: assert property (core_halted && !waking && deep
        |-> !comparator_enable) else $error("comparator on in deep sleep");
    a_mode_upper: assert property (rd && paddr == A_SMC |-> prdata[31:4] == 28'h0)
        else $error("sleep mode control upper bits not zero");
    a_detector_back: assert property (core_resume |=> brownout_detector_enable)
        else $error("detector not back on after wake");
    c_sleep: cover property (sleep_instr ##1 core_halted);
    c_wake: cover property (core_resume);
    c_block: cover property (periph_access && !periph_access_ok);
endmodule
bind spr_sleep_ctrl spr_sleep_ctrl_monitor #(.WAKE_CYCLES(WAKE_CYCLES)) u_mon (.clk, .reset,
    .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .sleep_instr, .wake_event,
    .crystal_clock_sel, .core_halted, .core_resume, .periph_access, .periph_sel,
    .periph_access_ok, .clock_run, .oscillator_run, .comparator_enable,
    .brownout_detector_enable);

// ===== tb/tb_top.sv
// testbench: registers, clock gating, sleep modes and brown-out sequence
`timescale 1ns/10ps
module tb_top;
    localparam int WAKE = 6;
    localparam logic [13:0] A_MCU = {spr_pkg::IDX_MCU_CONTROL, 2'b00};
    localparam logic [13:0] A_PWR = {spr_pkg::IDX_POWER_REDUCTION, 2'b00};
    localparam logic [13:0] A_SMC = {spr_pkg::IDX_SLEEP_MODE_CONTROL, 2'b00};
    logic clk, reset, psel, penable, pwrite, pready, sleep_instr, wake_event, core_halted;
    logic core_resume, periph_access, periph_access_ok, go_sleep, go_wake;
    logic timer2_async_select, adc_enabled, oscillator_run, timer2_clock_run;
    logic comparator_enable, adc_extended_conv, brownout_detector_enable, input_buffer_enable;
    logic [13:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [2:0] periph_sel;
    logic [7:0] v;
    logic [6:0] ec;
    spr_pkg::spr_gate_s clock_run;
    logic [31:0] rd_q[$];
    int n_fail = 0;
    int n_tests = 0;
    int seed = 63235;
    spr_sleep_ctrl #(.WAKE_CYCLES(WAKE)) u_dut (.clk, .reset, .clk_en(1'b1), .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr(), .sleep_instr, .wake_event,
        .crystal_clock_sel(1'b1), .core_halted, .core_resume, .timer2_async_select,
        .adc_enabled, .comparator_uses_ref(1'b0), .periph_access, .periph_sel,
        .periph_access_ok, .clock_run, .oscillator_run, .peripheral_io_clock_run(),
        .converter_clock_run(), .timer2_clock_run, .input_buffer_enable, .comparator_enable,
        .reference_keep(), .adc_extended_conv, .brownout_detector_enable);
    spr_core_model u_core (.clk, .reset, .go_sleep, .go_wake, .core_resume, .sleep_instr,
        .wake_event);
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task test_done;
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer; a read notes its expected word for the watcher
    task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d,
        input logic [31:0] e);
        int n = 0;
        if (!w) rd_q.push_back(e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            n_fail++;
            test_done();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    // read data stands from the setup edge; it is taken at the access edge
    always @(posedge clk) begin
        if (psel === 1'b1 && penable === 1'b1 && pwrite === 1'b0 && pready === 1'b1) begin
            chk(prdata, rd_q.pop_front());
        end
    end
    task automatic sleep_wake(input logic [2:0] m, input logic gate_on, input logic det_on);
        int n = 0;
        logic halt;
        halt = gate_on && m[2:1] != 2'b10;
        go_sleep <= 1'b1;
        @(posedge clk);
        go_sleep <= 1'b0;
        @(posedge clk);
        @(negedge clk);
        chk({31'h0, core_halted}, {31'h0, halt});
        if (halt) begin
            chk({31'h0, comparator_enable}, {31'h0, m <= 3'd1});
            chk({31'h0, input_buffer_enable}, {31'h0, m <= 3'd1});
            chk({31'h0, clock_run.uart}, {31'h0, m == 3'd0});
            chk({31'h0, oscillator_run || m < 3'd6}, 32'h1);
            chk({31'h0, brownout_detector_enable}, {31'h0, det_on});
            @(posedge clk);
            go_wake <= 1'b1;
            @(posedge clk);
            go_wake <= 1'b0;
            while (core_resume !== 1'b1 && n < 20) begin
                @(negedge clk);
                n++;
            end
            chk({31'h0, n <= WAKE + 1}, 32'h1);
            if (n >= 20) test_done();
            @(negedge clk);
            chk({31'h0, core_halted}, 32'h0);
            chk({31'h0, brownout_detector_enable}, 32'h1);
        end
        @(posedge clk);
    endtask
    initial begin
        reset = 1'b1;
        {psel, penable, pwrite, periph_access, go_sleep, go_wake} = '0;
        timer2_async_select = 1'b0;
        adc_enabled = 1'b0;
        paddr = '0;
        pwdata = '0;
        periph_sel = '0;
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        apb(1'b0, A_MCU, 32'h0, 32'h0);
        apb(1'b0, A_PWR, 32'h0, 32'h0);
        apb(1'b1, A_SMC, 32'hff, 32'h0);
        apb(1'b0, A_SMC, 32'h0, 32'h0f);
        apb(1'b1, A_MCU, 32'h13, 32'h0);
        apb(1'b0, A_MCU, 32'h0, 32'h13);
        apb(1'b1, 14'h3fc, 32'hffffffff, 32'h0);
        apb(1'b0, 14'h3fc, 32'h0, 32'h0);
        periph_access <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            v = 8'($random(seed));
            apb(1'b1, A_PWR, {24'h0, v}, 32'h0);
            apb(1'b0, A_PWR, 32'h0, {24'h0, v & 8'hef});
            ec = ~{v[7:5], v[3:0]};
            chk({25'h0, clock_run}, {25'h0, ec});
            for (int s = 0; s < 7; s++) begin
                periph_sel <= 3'(s);
                @(negedge clk);
                chk({31'h0, periph_access_ok}, {31'h0, ec[s]});
                @(posedge clk);
            end
        end
        apb(1'b1, A_PWR, 32'h40, 32'h0);
        timer2_async_select <= 1'b1;
        @(negedge clk);
        chk({31'h0, timer2_clock_run}, 32'h1);
        @(posedge clk);
        timer2_async_select <= 1'b0;
        @(negedge clk);
        chk({31'h0, timer2_clock_run}, 32'h0);
        @(posedge clk);
        apb(1'b1, A_PWR, 32'h0, 32'h0);
        chk({25'h0, clock_run}, 32'h7f);
        adc_enabled <= 1'b1;
        repeat (3) @(posedge clk);
        adc_enabled <= 1'b0;
        repeat (3) @(posedge clk);
        adc_enabled <= 1'b1;
        repeat (2) @(negedge clk);
        chk({31'h0, adc_extended_conv}, 32'h1);
        for (int m = 0; m < 8; m++) begin
            apb(1'b1, A_SMC, {28'h0, 3'(m), 1'b1}, 32'h0);
            sleep_wake(3'(m), 1'b1, 1'b1);
        end
        apb(1'b1, A_SMC, 32'h4, 32'h0);
        sleep_wake(3'd2, 1'b0, 1'b1);
        apb(1'b1, A_SMC, 32'h5, 32'h0);
        apb(1'b1, A_MCU, 32'h60, 32'h0);
        apb(1'b1, A_MCU, 32'h40, 32'h0);
        // sleep must reach the core inside the one-cycle active window
        @(posedge clk);
        sleep_wake(3'd2, 1'b1, 1'b0);
        apb(1'b0, A_MCU, 32'h0, 32'h0);
        apb(1'b1, A_MCU, 32'h60, 32'h0);
        repeat (5) @(posedge clk);
        apb(1'b1, A_MCU, 32'h40, 32'h0);
        sleep_wake(3'd2, 1'b1, 1'b1);
        repeat (4) @(posedge clk);
        test_done();
    end
endmodule
